// >>> hw/eps_pkg.sv
// eps_pkg: constants and carrier types for the wake filter and rail sequencer.
// assumes a single 25 MHz system clock; all times are converted to cycles here.
package eps_pkg;

  // clock rate
  localparam int unsigned CLK_MHZ           = 25;

  // wake pin filter times (us) and their cycle counts
  localparam int unsigned WAKE_DET_US       = 40;
  localparam int unsigned WAKE_FILT_US      = 20;
  localparam int unsigned WAKE_DET_CYC      = WAKE_DET_US * CLK_MHZ;
  localparam int unsigned WAKE_FILT_CYC     = WAKE_FILT_US * CLK_MHZ;
  localparam int unsigned WAKE_CNT_W        = 10;

  // nominal rail rise times (us) and cycle counts
  localparam int unsigned RISE_PRIMARY_US   = 640;
  localparam int unsigned RISE_SECONDARY_US = 320;
  localparam int unsigned RISE_STEP_UP_US   = 640;
  localparam int unsigned RISE_PRIMARY_CYC  = RISE_PRIMARY_US * CLK_MHZ;
  localparam int unsigned RISE_SECOND_CYC   = RISE_SECONDARY_US * CLK_MHZ;
  localparam int unsigned RISE_STEP_UP_CYC  = RISE_STEP_UP_US * CLK_MHZ;

  // short-to-ground detection window and reset release base delay
  localparam int unsigned STG_TIME_US       = 2000;
  localparam int unsigned STG_CYC           = STG_TIME_US * CLK_MHZ;
  localparam int unsigned RST_DLY_BASE_US   = 250;
  localparam int unsigned RST_DLY_BASE_CYC  = RST_DLY_BASE_US * CLK_MHZ;

  // monitor enable readback settling time, in cycles
  localparam int unsigned MON_DETECT_CYC    = 4;
  localparam int unsigned TIMER_W           = 20;

  // rail indices and stage masks
  localparam int unsigned RAIL_N            = 5;
  localparam int unsigned RAIL_PRIMARY      = 0;
  localparam int unsigned RAIL_SECONDARY    = 1;
  localparam int unsigned RAIL_STEP_UP      = 2;
  localparam int unsigned RAIL_MON_ONE      = 3;
  localparam int unsigned RAIL_MON_TWO      = 4;
  localparam logic [4:0]  STAGE1_MASK       = 5'h01;
  localparam logic [4:0]  STAGE2_MASK       = 5'h06;
  localparam logic [4:0]  STAGE3_MASK       = 5'h18;

  // device configuration register
  typedef struct packed {
    logic       wake_trigger_select;      // 0 edge, 1 level
    logic [1:0] reset_release_delay_sel;  // delay = base << sel
  } eps_cfg_t;

  localparam eps_cfg_t CFG_DEFAULT = '{wake_trigger_select: 1'b0,
                                       reset_release_delay_sel: 2'h0};

  // synchronised analog rail comparator inputs
  typedef struct packed {
    logic [4:0] uv_ok;     // above undervoltage threshold
    logic [4:0] ov;        // above overvoltage threshold
    logic [2:0] unused;    // internal rail flagged unused
    logic [1:0] mon_sense; // monitor enable pin reads high
  } eps_rail_cmp_t;

  typedef enum logic [1:0] {
    DEV_INIT     = 2'h0,
    DEV_ACTIVE   = 2'h1,
    DEV_DISABLED = 2'h2,
    DEV_LOCKED   = 2'h3
  } eps_dev_t;

  typedef enum logic [2:0] {
    SEQ_OFF     = 3'h0,
    SEQ_PRIMARY = 3'h1,
    SEQ_SECOND  = 3'h2,
    SEQ_DETECT  = 3'h3,
    SEQ_MONITOR = 3'h4,
    SEQ_DONE    = 3'h5
  } eps_seq_t;

endpackage : eps_pkg

// >>> hw/eps_wake_filter.sv
// eps_wake_filter: synchroniser and duration deglitch for the wake comparator.
// assumes the pin is asynchronous; emits one-cycle pulses on filtered edges.
`timescale 1ns/1ps
module eps_wake_filter
  import eps_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // raw comparator output
  input  wire logic pin_in,
  // filtered level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  import eps_pkg::*;

  logic                  sync1;
  logic                  sync2;
  logic [WAKE_CNT_W-1:0] cnt;
  wire                   differs = sync2 ^ level_out;
  wire                   expire  = differs && (cnt == WAKE_CNT_W'(WAKE_DET_CYC - 1));

  always_ff @(posedge clk_in)
  begin
    sync1 <= rst_in ? 1'b0 : pin_in;
    sync2 <= rst_in ? 1'b0 : sync1;
  end

  // dwell counter, clears on expiry, restarts on any bounce
  // same dwell for the low direction
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !differs || expire)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      level_out <= 1'b0;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end
    else
    begin
      level_out <= expire ? sync2 : level_out;
      rise_out  <= expire && sync2;
      fall_out  <= expire && !sync2;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_dwell_before_change: assert property (
    (level_out != $past(level_out)) |-> ($past(cnt) == WAKE_CNT_W'(WAKE_DET_CYC - 1)))
    else $error("filtered level changed before dwell time");
  a_glitch_rejected: assert property (
    (level_out != $past(level_out)) |-> ($past(cnt) >= WAKE_CNT_W'(WAKE_FILT_CYC)))
    else $error("short excursion reached filtered level");
  a_edge_pulse_match: assert property (
    rise_out |-> (level_out && !$past(level_out)))
    else $error("rise pulse without filtered rise");
  c_wake_rise: cover property (rise_out);

endmodule : eps_wake_filter

// >>> hw/eps_sequencer.sv
// eps_sequencer: wake handling, device state, staged rail enable, mcu reset.
// assumes analog comparators and monitor readback are asynchronous inputs,
// and that control pulses come from serial-port logic on the same clock.
//
// Summary of operation
// - wake counts as high only after 40 us above threshold; shorter glitches rejected.
// - wake counts as low only after 40 us below threshold; short dips ignored.
// - every filtered wake edge sets the sticky event flag; may start power-up.
// - a wake event alone never shuts the device down; mcu must request it.
// - a status output follows the filtered wake level at all times.
// - a config bit selects edge or level wake behaviour, applied by the device.
// - reset default is edge mode; only a filtered rising edge wakes.
// - level mode returns to ACTIVE from any state while wake is high.
// - ACTIVE to DISABLED allowed only while filtered wake is low.
// - enable primary, then secondary and step-up, then monitors, each after in-band.
// - sequencing runs on ACTIVE entry and skips rails marked unused.
// - advance only after undervoltage cleared and nominal rise time elapsed.
// - undervoltage monitoring arms at enable; first crossing reported once.
// - short-to-ground window is the timeout; fault then lock or continue.
// - mcu reset releases after its supply is in band for selected delay.
// - monitor enable readback high marks that channel as in use.
`timescale 1ns/1ps
module eps_sequencer
  import eps_pkg::*;
#(
  parameter int unsigned RISE_PRI_P   = eps_pkg::RISE_PRIMARY_CYC,
  parameter int unsigned RISE_SEC_P   = eps_pkg::RISE_SECOND_CYC,
  parameter int unsigned RISE_UP_P    = eps_pkg::RISE_STEP_UP_CYC,
  parameter int unsigned STG_P        = eps_pkg::STG_CYC,
  parameter int unsigned RST_BASE_P   = eps_pkg::RST_DLY_BASE_CYC
)
(
  // clock and reset
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  RST_IN,
  // wake pin comparator
  input  wire logic                  WAKE_PIN_IN,
  // configuration and control from serial logic
  input  wire logic                  CFG_WR_IN,
  input  wire eps_pkg::eps_cfg_t     CFG_DATA_IN,
  input  wire logic                  DEVICE_CONTROL_REQUEST_IN,
  input  wire logic                  HARD_RESET_EVENT_IN,
  input  wire logic                  LOCK_REQ_IN,
  input  wire logic                  STG_RESPONSE_LOCK_IN,
  input  wire logic                  WAKE_FLAG_CLR_IN,
  // analog rail comparators
  input  wire logic [4:0]            RAIL_UV_OK_IN,
  input  wire logic [4:0]            RAIL_OV_IN,
  input  wire logic [2:0]            RAIL_UNUSED_IN,
  input  wire logic [1:0]            MON_EN_SENSE_IN,
  // status
  output eps_pkg::eps_cfg_t          DEVICE_CONFIG_REGISTER_OUT,
  output eps_pkg::eps_dev_t          DEVICE_STATE_OUT,
  output logic                       WAKE_EVENT_FLAG_OUT,
  output logic                       WAKE_LEVEL_STATUS_OUT,
  output logic [1:0]                 MONITOR_IN_USE_OUT,
  output logic [4:0]                 UV_CROSS_EVENT_OUT,
  output logic [4:0]                 STG_FAULT_EVENT_OUT,
  output logic                       SEQ_DONE_OUT,
  // rail enables and mcu reset
  output logic [4:0]                 RAIL_EN_OUT,
  output logic                       MCU_RESET_N_OUT
);
  import eps_pkg::*;

  // synchronised comparator view
  eps_rail_cmp_t      cmp_async;
  eps_rail_cmp_t      cmp_s1;
  eps_rail_cmp_t      cmp;
  logic               wake_level;
  logic               wake_rise;
  logic               wake_fall;
  eps_seq_t           seq;
  eps_seq_t           next_seq;
  eps_dev_t           next_state;
  eps_cfg_t           next_cfg;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] rst_cnt;
  logic [4:0]         crossed;
  logic [4:0]         next_en;

  assign cmp_async = '{uv_ok: RAIL_UV_OK_IN, ov: RAIL_OV_IN,
                       unused: RAIL_UNUSED_IN, mon_sense: MON_EN_SENSE_IN};

  genvar g;
  generate
    for (g = 0; g < $bits(eps_rail_cmp_t); g++)
    begin : g_sync
      always_ff @(posedge SYS_CLK_IN)
      begin
        cmp_s1[g] <= RST_IN ? 1'b0 : cmp_async[g];
        cmp[g]    <= RST_IN ? 1'b0 : cmp_s1[g];
      end
    end
  endgenerate

  eps_wake_filter u_wake (
    .clk_in    (SYS_CLK_IN),
    .rst_in    (RST_IN),
    .pin_in    (WAKE_PIN_IN),
    .level_out (wake_level),
    .rise_out  (wake_rise),
    .fall_out  (wake_fall)
  );

  // rail qualification
  wire [4:0] in_band   = cmp.uv_ok & ~cmp.ov;
  wire [4:0] used      = {MONITOR_IN_USE_OUT, ~cmp.unused};
  wire [4:0] stage_msk = (seq == SEQ_PRIMARY) ? STAGE1_MASK :
                         (seq == SEQ_SECOND)  ? STAGE2_MASK :
                         (seq == SEQ_MONITOR) ? STAGE3_MASK : 5'h00;
  wire [4:0] stage_use = stage_msk & used;
  // stage is good when every used rail in it is in band
  wire       stage_ok  = &(in_band | ~stage_use);
  // step-up rise time dominates the secondary one when both are used
  wire [TIMER_W-1:0] rise_tgt =
      (seq == SEQ_PRIMARY && used[RAIL_PRIMARY])   ? TIMER_W'(RISE_PRI_P) :
      (seq == SEQ_SECOND  && used[RAIL_STEP_UP])   ? TIMER_W'(RISE_UP_P)  :
      (seq == SEQ_SECOND  && used[RAIL_SECONDARY]) ? TIMER_W'(RISE_SEC_P) : '0;
  // in band and rise time both required
  wire       rise_done = (timer >= rise_tgt);
  wire       advance   = stage_ok && rise_done;
  wire       stg_hit   = (stage_use != 5'h00) && !stage_ok &&
                         (timer >= TIMER_W'(STG_P - 1));
  wire       stg_lock  = stg_hit && STG_RESPONSE_LOCK_IN;
  wire       seq_step  = advance || (stg_hit && !STG_RESPONSE_LOCK_IN);
  wire       detect_end = (seq == SEQ_DETECT) && (timer >= TIMER_W'(MON_DETECT_CYC));
  wire       active    = (DEVICE_STATE_OUT == DEV_ACTIVE);

  // edge mode wakes only on a rising edge
  wire       lvl_mode  = DEVICE_CONFIG_REGISTER_OUT.wake_trigger_select;
  wire       wake_go   = lvl_mode ? wake_level : wake_rise;
  // level mode and high level force re-entry
  wire       lvl_force = lvl_mode && wake_level;
  // disable request honoured only with wake low
  wire       dis_ok    = DEVICE_CONTROL_REQUEST_IN && !wake_level;

  // device state
  // no branch leaves ACTIVE on a wake event
  always_comb
  begin
    next_state = DEVICE_STATE_OUT;
    unique case (DEVICE_STATE_OUT)
      DEV_INIT:     next_state = wake_go ? DEV_ACTIVE : DEV_INIT;
      DEV_ACTIVE:
      begin
        if (HARD_RESET_EVENT_IN)
          next_state = DEV_INIT;
        else if (LOCK_REQ_IN || stg_lock)
          next_state = DEV_LOCKED;
        else if (dis_ok)
          next_state = DEV_DISABLED;
      end
      DEV_DISABLED: next_state = wake_go ? DEV_ACTIVE : DEV_DISABLED;
      DEV_LOCKED:   next_state = lvl_force ? DEV_ACTIVE : DEV_LOCKED;
    endcase
  end

  wire       cfg_revert = active && (next_state == DEV_DISABLED);
  always_comb
  begin
    next_cfg = DEVICE_CONFIG_REGISTER_OUT;
    if (cfg_revert)
      next_cfg = CFG_DEFAULT;
    else if (CFG_WR_IN)
      next_cfg = CFG_DATA_IN;
  end

  // sequencer
  // runs on ACTIVE entry; empty stages pass straight through
  always_comb
  begin
    next_seq = seq;
    if (!active)
      next_seq = SEQ_OFF;
    else
    begin
      unique case (seq)
        SEQ_OFF:     next_seq = SEQ_PRIMARY;
        SEQ_PRIMARY: next_seq = seq_step ? SEQ_SECOND : seq;
        SEQ_SECOND:  next_seq = seq_step ? SEQ_DETECT : seq;
        SEQ_DETECT:  next_seq = detect_end ? SEQ_MONITOR : seq;
        SEQ_MONITOR: next_seq = seq_step ? SEQ_DONE : seq;
        SEQ_DONE:    next_seq = seq;
        default:     next_seq = SEQ_OFF;
      endcase
    end
  end

  // monitors driven during detection to test readback
  always_comb
  begin
    next_en = RAIL_EN_OUT;
    if (!active || stg_lock)
      next_en = 5'h00;
    else if (next_seq == SEQ_PRIMARY)
      next_en = STAGE1_MASK & used;
    else if (next_seq == SEQ_SECOND)
      next_en = RAIL_EN_OUT | (STAGE2_MASK & used);
    else if (next_seq == SEQ_DETECT)
      next_en = RAIL_EN_OUT | STAGE3_MASK;
    else if (seq == SEQ_DETECT)
      next_en = {cmp.mon_sense, RAIL_EN_OUT[2:0]};
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      DEVICE_STATE_OUT           <= DEV_INIT;
      DEVICE_CONFIG_REGISTER_OUT <= CFG_DEFAULT;
      seq                        <= SEQ_OFF;
      RAIL_EN_OUT                <= 5'h00;
      SEQ_DONE_OUT               <= 1'b0;
    end
    else
    begin
      DEVICE_STATE_OUT           <= next_state;
      DEVICE_CONFIG_REGISTER_OUT <= next_cfg;
      seq                        <= next_seq;
      RAIL_EN_OUT                <= next_en;
      SEQ_DONE_OUT               <= (next_seq == SEQ_DONE);
    end
  end

  // stage timer restarts on each stage change, saturates at the window
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN || next_seq != seq)
      timer <= '0;
    else if (timer != TIMER_W'(STG_P))
      timer <= timer + 1'b1;
  end

  // readback result latched at the end of detection
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
      MONITOR_IN_USE_OUT <= 2'h0;
    else if (detect_end)
      MONITOR_IN_USE_OUT <= cmp.mon_sense;
  end

  // filtered edges set the flag; set wins over clear
  always_ff @(posedge SYS_CLK_IN)
  begin
    WAKE_EVENT_FLAG_OUT   <= !RST_IN && (wake_rise || wake_fall ||
                             (WAKE_EVENT_FLAG_OUT && !WAKE_FLAG_CLR_IN));
    WAKE_LEVEL_STATUS_OUT <= !RST_IN && wake_level;
  end

  // monitoring armed at enable, first crossing reported once
  // fault pulse for each used rail still out of band at timeout
  always_ff @(posedge SYS_CLK_IN)
  begin
    crossed             <= RST_IN ? 5'h00 : RAIL_EN_OUT & (crossed | cmp.uv_ok);
    UV_CROSS_EVENT_OUT  <= RST_IN ? 5'h00 : RAIL_EN_OUT & cmp.uv_ok & ~crossed;
    STG_FAULT_EVENT_OUT <= (RST_IN || !stg_hit) ? 5'h00 : stage_use & ~in_band;
  end

  // mcu supply must stay in band for the selected delay
  // once released, a new delay setting must not pulse the reset again
  wire               mcu_ok  = RAIL_EN_OUT[RAIL_PRIMARY] && in_band[RAIL_PRIMARY];
  wire [TIMER_W-1:0] rst_tgt = TIMER_W'(RST_BASE_P) <<
                               DEVICE_CONFIG_REGISTER_OUT.reset_release_delay_sel;
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN || !mcu_ok)
    begin
      rst_cnt         <= '0;
      MCU_RESET_N_OUT <= 1'b0;
    end
    else
    begin
      rst_cnt         <= (rst_cnt >= rst_tgt) ? rst_cnt : rst_cnt + 1'b1;
      MCU_RESET_N_OUT <= MCU_RESET_N_OUT || (rst_cnt >= rst_tgt);
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_flag_on_event: assert property (
    (wake_rise || wake_fall) |=> WAKE_EVENT_FLAG_OUT)
    else $error("wake event did not set flag");
  a_no_event_off: assert property (
    (active && (wake_rise || wake_fall) && !DEVICE_CONTROL_REQUEST_IN &&
     !HARD_RESET_EVENT_IN && !LOCK_REQ_IN && !stg_lock) |=> active)
    else $error("wake event left ACTIVE");
  a_level_status: assert property (
    WAKE_LEVEL_STATUS_OUT == $past(wake_level))
    else $error("level status does not track filter");
  a_edge_only_rise: assert property (
    (DEVICE_STATE_OUT == DEV_DISABLED && !lvl_mode && !wake_rise)
    |=> DEVICE_STATE_OUT == DEV_DISABLED)
    else $error("edge mode woke without rising edge");
  a_level_reentry: assert property (
    (!active && lvl_force) |=> active)
    else $error("level mode did not re-enter ACTIVE");
  a_disable_low: assert property (
    (active ##1 DEVICE_STATE_OUT == DEV_DISABLED) |-> !$past(wake_level))
    else $error("disabled entered with wake high");
  a_cfg_revert: assert property (
    (active ##1 DEVICE_STATE_OUT == DEV_DISABLED)
    |-> DEVICE_CONFIG_REGISTER_OUT == CFG_DEFAULT)
    else $error("config not restored on disable");
  a_stage_order: assert property (
    $rose(RAIL_EN_OUT[RAIL_STEP_UP]) |-> $past(RAIL_EN_OUT[RAIL_PRIMARY]))
    else $error("stage two enabled before primary");
  a_rise_wait: assert property (
    (seq == SEQ_PRIMARY && next_seq == SEQ_SECOND && !stg_hit && used[RAIL_PRIMARY])
    |-> (timer >= TIMER_W'(RISE_PRI_P) && in_band[RAIL_PRIMARY]))
    else $error("advanced before rise time");
  a_uv_once: assert property (
    UV_CROSS_EVENT_OUT[RAIL_PRIMARY] |=> !UV_CROSS_EVENT_OUT[RAIL_PRIMARY])
    else $error("undervoltage crossing reported twice");
  a_stg_timeout: assert property (
    (STG_FAULT_EVENT_OUT != 5'h00) |-> $past(timer) >= TIMER_W'(STG_P - 1))
    else $error("fault before detection window");
  a_reset_delay: assert property (
    $rose(MCU_RESET_N_OUT) |-> $past(rst_cnt) >= $past(rst_tgt) && $past(mcu_ok))
    else $error("mcu reset released early");

  c_power_up: cover property (SEQ_DONE_OUT && MCU_RESET_N_OUT);
  c_disable: cover property (active ##1 DEVICE_STATE_OUT == DEV_DISABLED);
  c_stg_fault: cover property (STG_FAULT_EVENT_OUT != 5'h00);
  c_lock_reentry: cover property (DEVICE_STATE_OUT == DEV_LOCKED ##1 active);

endmodule : eps_sequencer

// >>> test/eps_rail_model.sv
// eps_rail_model: behavioural rails and monitor enable readback.
// assumes the sequencer enables drive the rails; bench commands faults.
`timescale 1ns/1ps
module eps_rail_model
#(
  parameter int unsigned RAMP = 5
)
(
  // clock
  input  wire logic       clk_in,
  // enables and commanded faults
  input  wire logic [4:0] en_in,
  input  wire logic [4:0] stuck_in,
  input  wire logic [1:0] absent_in,
  // comparator outputs
  output logic [4:0]      uv_ok_out,
  output logic [1:0]      sense_out
);
  logic [7:0] ramp [5];
  for (genvar i = 0; i < 5; i++)
  begin : g_rail
    // ramp restarts whenever the rail is switched off
    always_ff @(posedge clk_in)
      if (!en_in[i])
        ramp[i] <= 8'h00;
      else if (ramp[i] < RAMP)
        ramp[i] <= ramp[i] + 8'h01;
    assign uv_ok_out[i] = en_in[i] && (ramp[i] >= RAMP) && !stuck_in[i];
  end
  // pin pulled down when no regulator is fitted
  assign sense_out = en_in[4:3] & ~absent_in;
endmodule : eps_rail_model

// >>> test/tb_top.sv
// tb_top: self-checking bench for the wake filter and rail sequencer.
// assumes short rise and timeout parameters; wake dwell stays 1000 cycles.
`timescale 1ns/1ps
module tb_top;
  import eps_pkg::*;
  localparam int unsigned PRI = 40;
  logic       clk, rst, wake, cfg_wr, dreq, hrst, lreq, stg_lock, fclr, flag, lvl, done, mrst_n;
  logic [4:0] uv_ok, en, uv_ev, stg_ev, stuck, ov;
  logic [2:0] unused;
  logic [1:0] sense, inuse, absent;
  eps_cfg_t   cfg_d, cfg_q;
  eps_dev_t   st;
  int         failures, comparisons, cyc, seed, t0, g, uv_cnt;

  eps_sequencer #(.RISE_PRI_P(PRI), .RISE_SEC_P(20), .RISE_UP_P(40), .STG_P(200),
    .RST_BASE_P(10)) u_dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .WAKE_PIN_IN(wake), .CFG_WR_IN(cfg_wr),
    .CFG_DATA_IN(cfg_d), .DEVICE_CONTROL_REQUEST_IN(dreq), .HARD_RESET_EVENT_IN(hrst),
    .LOCK_REQ_IN(lreq), .STG_RESPONSE_LOCK_IN(stg_lock), .WAKE_FLAG_CLR_IN(fclr),
    .RAIL_UV_OK_IN(uv_ok), .RAIL_OV_IN(ov), .RAIL_UNUSED_IN(unused),
    .MON_EN_SENSE_IN(sense), .DEVICE_CONFIG_REGISTER_OUT(cfg_q), .DEVICE_STATE_OUT(st),
    .WAKE_EVENT_FLAG_OUT(flag), .WAKE_LEVEL_STATUS_OUT(lvl), .MONITOR_IN_USE_OUT(inuse),
    .UV_CROSS_EVENT_OUT(uv_ev), .STG_FAULT_EVENT_OUT(stg_ev), .SEQ_DONE_OUT(done),
    .RAIL_EN_OUT(en), .MCU_RESET_N_OUT(mrst_n));

  eps_rail_model #(.RAMP(5)) u_rails (.clk_in(clk), .en_in(en), .stuck_in(stuck),
    .absent_in(absent), .uv_ok_out(uv_ok), .sense_out(sense));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  // bounded wait for a device state
  task automatic wait_st(input eps_dev_t s);
    int n;
    n = 0;
    while (st !== s && n < 1500)
    begin
      tick(1);
      n++;
    end
  endtask : wait_st

  // primary crossing pulses, counted at the edge that ends them
  always @(posedge clk)
    if (uv_ev[0] === 1'b1)
      uv_cnt++;

  // hang guard, well above the planned run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    seed = 62191;
    {rst, wake, cfg_wr, dreq, hrst, lreq, stg_lock, fclr} = 8'h80;
    cfg_d = CFG_DEFAULT;
    stuck = 5'h00;
    ov = 5'h00;
    unused = 3'h0;
    absent = 2'($random(seed));
    tick(3);
    rst = 1'b0;
    chk("state", 8'(st), 8'(DEV_INIT));
    chk("cfg", 8'(cfg_q), 8'(CFG_DEFAULT));
    chk("mcu_rst", 8'(mrst_n), 8'h00);
    g = 10 + ({$random(seed)} % 900);
    // glitch shorter than dwell
    wake = 1'b1;
    tick(g);
    wake = 1'b0;
    tick(1100);
    chk("lvl", 8'(lvl), 8'h00);
    chk("flag", 8'(flag), 8'h00);
    wake = 1'b1;
    wait_st(DEV_ACTIVE);
    t0 = cyc;
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    tick(2);
    chk("lvl", 8'(lvl), 8'h01);
    chk("flag", 8'(flag), 8'h01);
    while (en[1] !== 1'b1 && cyc - t0 < 300) tick(1);
    chk("rise", 8'(cyc - t0 >= PRI), 8'h01);
    chk("stage2", 8'(en), 8'h07);
    while (done !== 1'b1 && cyc - t0 < 600) tick(1);
    chk("in_use", 8'(inuse), {6'h00, ~absent});
    chk("en", 8'(en), {3'h0, ~absent, 3'h7});
    chk("mcu_rst", 8'(mrst_n), 8'h01);
    chk("uv_once", 8'(uv_cnt), 8'h01);
    cfg_d = '{wake_trigger_select: 1'b0, reset_release_delay_sel: 2'($random(seed))};
    pulse(cfg_wr);
    tick(1);
    chk("cfg", 8'(cfg_q), 8'(cfg_d));
    chk("mcu_rst", 8'(mrst_n), 8'h01);
    pulse(dreq);
    tick(2);
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    pulse(fclr);
    tick(1);
    chk("flag", 8'(flag), 8'h00);
    wake = 1'b0;
    tick(g);
    wake = 1'b1;
    tick(1100);
    chk("lvl", 8'(lvl), 8'h01);
    wake = 1'b0;
    tick(1010);
    chk("lvl", 8'(lvl), 8'h00);
    chk("flag", 8'(flag), 8'h01);
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    pulse(dreq);
    tick(2);
    chk("state", 8'(st), 8'(DEV_DISABLED));
    chk("cfg", 8'(cfg_q), 8'(CFG_DEFAULT));
    chk("en", 8'(en), 8'h00);
    wake = 1'b1;
    wait_st(DEV_ACTIVE);
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    cfg_d = '{wake_trigger_select: 1'b1, reset_release_delay_sel: 2'h0};
    pulse(cfg_wr);
    pulse(lreq);
    chk("state", 8'(st), 8'(DEV_LOCKED));
    tick(4);
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    // restart the sequence with a stuck secondary and no step-up
    stuck = 5'h02;
    unused = 3'h4;
    pulse(hrst);
    t0 = cyc;
    while (stg_ev[1] !== 1'b1 && cyc - t0 < 500) tick(1);
    chk("stg", 8'(stg_ev[1]), 8'h01);
    chk("skip", 8'(en[2]), 8'h00);
    tick(3);
    chk("state", 8'(st), 8'(DEV_ACTIVE));
    while (done !== 1'b1 && cyc - t0 < 800) tick(1);
    chk("done", 8'(done), 8'h01);
    // primary above overvoltage takes the mcu supply out of band
    ov = 5'h01;
    tick(4);
    chk("mcu_rst", 8'(mrst_n), 8'h00);
    ov = 5'h00;
    tick(20);
    chk("mcu_rst", 8'(mrst_n), 8'h01);
    // same stuck rail, lock response this time
    stg_lock = 1'b1;
    pulse(hrst);
    t0 = cyc;
    while (stg_ev[1] !== 1'b1 && cyc - t0 < 500) tick(1);
    chk("stg", 8'(stg_ev[1]), 8'h01);
    chk("state", 8'(st), 8'(DEV_LOCKED));
    chk("en", 8'(en), 8'h00);
    test_done();
  end
endmodule : tb_top
